// ===== common/arith_timing_defs.vh
// timing table and encodings for the add/subtract/compare timing unit
// Behaviour
// - word_reg with short_direct_operand: 4 bytes 4 states, source 3 and 3.
// - byte_reg with long_direct_operand: 5 bytes 3 states, source 4 and 2, plus external.
// - word_reg with long_direct_operand: 5 bytes 4 states, source 4 and 3, plus memory.
// - byte_reg through word pointer 4/3, dword pointer 4/4; source one less each.
// - carry form with bank_byte_reg: uses carry, 1 byte 1 state, source 2 and 2.
// - carry form with immediate or short direct: 2 bytes, 1 state, both modes.
// - carry form through pointer_byte_reg: 1 byte 2 states, source 2 bytes 3 states.
// - flagged direct form on port 0 to 3 adds 1 state, peripheral register adds 2.
// - byte form flagged for external memory adds wait states plus two; word long form adds twice that.
// - compare two word registers: 3 bytes 3 states, source 2 and 2.
// - compare two dword registers: 3 bytes 5 states, source 2 and 4.
// - compare byte_reg with immediate byte: 4 bytes 3 states, source 3 and 2.
// - compare word_reg with 16-bit immediate: 5 bytes 4 states, source 4 and 3.
// - compare dword_reg with zero-extended immediate: 5 bytes 6 states, source 4 and 5.
// - compare dword_reg with one-filled immediate: same 5/6 and 4/5 costs.
// - compare byte_reg with short direct: 4/3, source 3/2, plus port or peripheral.
// - compare word_reg with short direct: 4 bytes 4 states, source 3 and 3.
// - compare byte_reg with long direct: 5/3, source 4/2, plus external wait penalty.
// - compare word_reg with long direct: 5/4, source 4/3, plus memory penalty.
// - compare byte_reg through word pointer 4/3, dword pointer 4/4; source one less.
`ifndef ARITH_TIMING_DEFS_VH
`define ARITH_TIMING_DEFS_VH

// operation classes
`define OP_PLAIN          2'h0
`define OP_WITH_CARRY     2'h1
`define OP_COMPARE        2'h2

// operand forms
`define FORM_ACC_BANK     5'h00
`define FORM_ACC_SHORT    5'h01
`define FORM_ACC_PTR      5'h02
`define FORM_ACC_IMM      5'h03
`define FORM_BYTE_BYTE    5'h04
`define FORM_WORD_WORD    5'h05
`define FORM_DWORD_DWORD  5'h06
`define FORM_BYTE_IMM     5'h07
`define FORM_WORD_IMM     5'h08
`define FORM_DWORD_IMM0   5'h09
`define FORM_DWORD_IMM1   5'h0a
`define FORM_BYTE_SHORT   5'h0b
`define FORM_WORD_SHORT   5'h0c
`define FORM_BYTE_LONG    5'h0d
`define FORM_WORD_LONG    5'h0e
`define FORM_BYTE_AT_WORD 5'h0f
`define FORM_BYTE_AT_DW   5'h10

// where the memory operand lies
`define LOC_INTERNAL      2'h0
`define LOC_IO_PORT       2'h1
`define LOC_PERIPH_SFR    2'h2
`define LOC_EXTERNAL      2'h3

// operand widths
`define WID_BYTE          2'h0
`define WID_WORD          2'h1
`define WID_DWORD         2'h2

// penalties in states
`define PEN_IO_PORT       6'h01
`define PEN_PERIPH_SFR    6'h02
`define PEN_EXT_BASE      6'h02

// penalty classes of a form
`define PCL_NONE          2'h0
`define PCL_SFR           2'h1
`define PCL_EXT1          2'h2
`define PCL_EXT2          2'h3

// reset values
`define RST_BYTES         3'h0
`define RST_STATES        6'h00
`define RST_WORD          32'h00000000

`endif

// ===== verilog/arith_compare_timing.v
// length, state timing and arithmetic of add/subtract, carry and compare forms
`timescale 1ns/10ps
`default_nettype none
`include "arith_timing_defs.vh"

module arith_compare_timing (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        start,
    input  wire [1:0]  op_class,
    input  wire        subtract,
    input  wire [4:0]  form,
    input  wire        source_mode,
    input  wire [1:0]  operand_loc,
    input  wire [3:0]  wait_states,
    input  wire [31:0] dest_operand,
    input  wire [31:0] src_operand,
    input  wire        carry_in,
    output reg         busy,
    output reg         done,
    output reg         illegal,
    output reg  [2:0]  instr_bytes,
    output reg  [5:0]  exec_states,
    output reg  [31:0] result,
    output reg         write_back,
    output reg         carry_out,
    output reg         overflow,
    output reg         zero,
    output reg         negative
);

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg        state;
    reg  [5:0] remaining;
    // the class is held since the op_class input may change while busy
    reg  [1:0] op_class_held;

    reg  [2:0] base_bytes;
    reg  [5:0] base_states;
    reg  [1:0] pen_class;
    reg  [1:0] width;
    reg        form_ok;
    reg  [5:0] penalty;
    reg  [5:0] next_states;
    reg  [2:0] next_bytes;

    reg  [31:0] opa;
    reg  [31:0] opb;
    reg  [32:0] raw;
    reg  [31:0] next_result;
    reg         use_carry;
    reg         is_sub;
    reg         next_cy;
    reg         next_ov;
    reg         next_n;
    reg         sa;
    reg         sb;

    // binary mode table; source mode adjusts below
    always @* begin
        base_bytes  = 3'h0;
        base_states = 6'h00;
        pen_class   = `PCL_NONE;
        width       = `WID_BYTE;
        form_ok     = 1'b1;
        case (form)
            `FORM_ACC_BANK: begin
                base_bytes  = source_mode ? 3'h2 : 3'h1;
                base_states = source_mode ? 6'h02 : 6'h01;
            end
            `FORM_ACC_SHORT: begin
                base_bytes  = 3'h2;
                base_states = 6'h01;
                pen_class   = `PCL_SFR;
            end
            `FORM_ACC_PTR: begin
                base_bytes  = source_mode ? 3'h2 : 3'h1;
                base_states = source_mode ? 6'h03 : 6'h02;
            end
            `FORM_ACC_IMM: begin
                base_bytes  = 3'h2;
                base_states = 6'h01;
            end
            `FORM_BYTE_BYTE: begin
                base_bytes  = source_mode ? 3'h2 : 3'h3;
                base_states = source_mode ? 6'h01 : 6'h02;
            end
            `FORM_WORD_WORD: begin
                base_bytes  = source_mode ? 3'h2 : 3'h3;
                base_states = source_mode ? 6'h02 : 6'h03;
                width       = `WID_WORD;
            end
            `FORM_DWORD_DWORD: begin
                base_bytes  = source_mode ? 3'h2 : 3'h3;
                base_states = source_mode ? 6'h04 : 6'h05;
                width       = `WID_DWORD;
            end
            `FORM_BYTE_IMM: begin
                base_bytes  = source_mode ? 3'h3 : 3'h4;
                base_states = source_mode ? 6'h02 : 6'h03;
            end
            `FORM_WORD_IMM: begin
                base_bytes  = source_mode ? 3'h4 : 3'h5;
                base_states = source_mode ? 6'h03 : 6'h04;
                width       = `WID_WORD;
            end
            `FORM_DWORD_IMM0: begin
                base_bytes  = source_mode ? 3'h4 : 3'h5;
                base_states = source_mode ? 6'h05 : 6'h06;
                width       = `WID_DWORD;
            end
            `FORM_DWORD_IMM1: begin
                base_bytes  = source_mode ? 3'h4 : 3'h5;
                base_states = source_mode ? 6'h05 : 6'h06;
                width       = `WID_DWORD;
                // the one-filled immediate exists only as a compare
                form_ok     = (op_class == `OP_COMPARE);
            end
            `FORM_BYTE_SHORT: begin
                base_bytes  = source_mode ? 3'h3 : 3'h4;
                base_states = source_mode ? 6'h02 : 6'h03;
                pen_class   = `PCL_SFR;
            end
            `FORM_WORD_SHORT: begin
                base_bytes  = source_mode ? 3'h3 : 3'h4;
                base_states = source_mode ? 6'h03 : 6'h04;
                width       = `WID_WORD;
            end
            `FORM_BYTE_LONG: begin
                base_bytes  = source_mode ? 3'h4 : 3'h5;
                base_states = source_mode ? 6'h02 : 6'h03;
                pen_class   = `PCL_EXT1;
            end
            `FORM_WORD_LONG: begin
                base_bytes  = source_mode ? 3'h4 : 3'h5;
                base_states = source_mode ? 6'h03 : 6'h04;
                width       = `WID_WORD;
                // two bus cycles for a word, so the wait penalty is doubled
                pen_class   = `PCL_EXT2;
            end
            `FORM_BYTE_AT_WORD: begin
                base_bytes  = source_mode ? 3'h3 : 3'h4;
                base_states = source_mode ? 6'h02 : 6'h03;
                pen_class   = `PCL_EXT1;
            end
            `FORM_BYTE_AT_DW: begin
                base_bytes  = source_mode ? 3'h3 : 3'h4;
                base_states = source_mode ? 6'h03 : 6'h04;
                pen_class   = `PCL_EXT1;
            end
            default: begin
                form_ok = 1'b0;
            end
        endcase
        // accumulator forms carry no plain or compare variant here
        if (form <= `FORM_ACC_IMM && op_class != `OP_WITH_CARRY) begin
            form_ok = 1'b0;
        end
        if (op_class == `OP_WITH_CARRY && form > `FORM_ACC_IMM) begin
            form_ok = 1'b0;
        end
        if (op_class == 2'h3) begin
            form_ok = 1'b0;
        end
    end

    // penalty only for forms that carry the matching flag
    always @* begin
        penalty = 6'h00;
        case (pen_class)
            `PCL_SFR: begin
                if (operand_loc == `LOC_IO_PORT) begin
                    penalty = `PEN_IO_PORT;
                end else if (operand_loc == `LOC_PERIPH_SFR) begin
                    penalty = `PEN_PERIPH_SFR;
                end
            end
            `PCL_EXT1: begin
                if (operand_loc == `LOC_EXTERNAL) begin
                    penalty = {2'h0, wait_states} + `PEN_EXT_BASE;
                end
            end
            `PCL_EXT2: begin
                if (operand_loc == `LOC_EXTERNAL) begin
                    penalty = {1'b0, wait_states, 1'b0} + `PEN_EXT_BASE + `PEN_EXT_BASE;
                end
            end
            default: begin
                penalty = 6'h00;
            end
        endcase
        next_states = base_states + penalty;
        next_bytes  = base_bytes;
    end

    // operand shaping and arithmetic at the form's width
    always @* begin
        opa = dest_operand;
        opb = src_operand;
        case (width)
            `WID_BYTE: begin
                opa = {24'h000000, dest_operand[7:0]};
                opb = {24'h000000, src_operand[7:0]};
            end
            `WID_WORD: begin
                opa = {16'h0000, dest_operand[15:0]};
                opb = {16'h0000, src_operand[15:0]};
            end
            default: begin
                opa = dest_operand;
                opb = src_operand;
            end
        endcase
        if (form == `FORM_DWORD_IMM0) begin
            opb = {16'h0000, src_operand[15:0]};
        end else if (form == `FORM_DWORD_IMM1) begin
            opb = {16'hffff, src_operand[15:0]};
        end
        use_carry = (op_class == `OP_WITH_CARRY) & carry_in;
        is_sub    = (op_class == `OP_COMPARE) | subtract;
        if (is_sub) begin
            raw = {1'b0, opa} - {1'b0, opb} - {32'h00000000, use_carry};
        end else begin
            raw = {1'b0, opa} + {1'b0, opb} + {32'h00000000, use_carry};
        end
        case (width)
            `WID_BYTE: begin
                next_result = {24'h000000, raw[7:0]};
                next_cy     = raw[8];
                sa          = opa[7];
                sb          = opb[7];
                next_n      = raw[7];
            end
            `WID_WORD: begin
                next_result = {16'h0000, raw[15:0]};
                next_cy     = raw[16];
                sa          = opa[15];
                sb          = opb[15];
                next_n      = raw[15];
            end
            default: begin
                next_result = raw[31:0];
                next_cy     = raw[32];
                sa          = opa[31];
                sb          = opb[31];
                next_n      = raw[31];
            end
        endcase
        if (is_sub) begin
            next_ov = (sa != sb) & (next_n != sa);
        end else begin
            next_ov = (sa == sb) & (next_n != sa);
        end
    end

    // one state per clock; done pulses after the last state
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state       <= ST_IDLE;
            remaining   <= `RST_STATES;
            busy        <= 1'b0;
            done        <= 1'b0;
            illegal     <= 1'b0;
            instr_bytes <= `RST_BYTES;
            exec_states <= `RST_STATES;
            result      <= `RST_WORD;
            write_back  <= 1'b0;
            carry_out   <= 1'b0;
            overflow    <= 1'b0;
            zero        <= 1'b0;
            negative    <= 1'b0;
        end else begin
            done       <= 1'b0;
            write_back <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        illegal <= ~form_ok;
                        if (form_ok) begin
                            instr_bytes <= next_bytes;
                            exec_states <= next_states;
                            remaining   <= next_states - 6'h01;
                            result      <= next_result;
                            carry_out   <= next_cy;
                            overflow    <= next_ov;
                            zero        <= (next_result == 32'h00000000);
                            negative    <= next_n;
                            busy        <= 1'b1;
                            state       <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (remaining == 6'h00) begin
                        busy  <= 1'b0;
                        done  <= 1'b1;
                        // a compare only leaves flags behind
                        write_back <= (op_class_held != `OP_COMPARE);
                        state <= ST_IDLE;
                    end else begin
                        remaining <= remaining - 6'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy  <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op_class_held <= `OP_PLAIN;
        end else if (state == ST_IDLE && start && form_ok) begin
            op_class_held <= op_class;
        end
    end

endmodule
`default_nettype wire

// ===== tb/operand_store.sv
// data-side model that hands the two operands to the timing unit
`timescale 1ns/10ps
`default_nettype none
module operand_store (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        valid,
    input  wire logic [31:0] a_in,
    input  wire logic [31:0] b_in,
    output var  logic [31:0] dest_operand,
    output var  logic [31:0] src_operand
);
    // a released bus shows the inverse of its last value, so a late sample is caught
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dest_operand <= 32'h00000000;
            src_operand  <= 32'h00000000;
        end else if (valid) begin
            dest_operand <= a_in;
            src_operand  <= b_in;
        end else begin
            dest_operand <= ~dest_operand;
            src_operand  <= ~src_operand;
        end
    end
endmodule
`default_nettype wire

// ===== tb/arith_compare_timing_asserts.sv
// concurrent checks on the add/subtract/compare timing unit
`timescale 1ns/10ps
`default_nettype none
module arith_compare_timing_asserts (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       start,
    input wire logic [1:0] op_class,
    input wire logic [4:0] form,
    input wire logic       source_mode,
    input wire logic [1:0] operand_loc,
    input wire logic [3:0] wait_states,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       illegal,
    input wire logic [2:0] instr_bytes,
    input wire logic [5:0] exec_states,
    input wire logic       write_back
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       take;
    logic [1:0] cls;
    logic [5:0] cnt;
    assign take = start && !busy;
    // class is latched so inputs may change while the unit runs
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cls <= 2'h0;
            cnt <= 6'h00;
        end else begin
            cls <= take ? op_class : cls;
            cnt <= busy ? cnt + 6'h01 : 6'h00;
        end
    end
    a_state_count: assert property (done |-> cnt == exec_states)
        else $error("busy span differs from state count");
    a_done_single: assert property (done && !start |-> !busy ##1 !done)
        else $error("done not a single idle pulse");
    a_cmp_no_write: assert property (done && cls == 2'h2 |-> !write_back)
        else $error("compare wrote an operand back");
    a_word_word: assert property (take && op_class == 2'h2 && form == 5'h05 |=>
        instr_bytes == ($past(source_mode) ? 3'h2 : 3'h3) && exec_states == {4'h0, instr_bytes[1:0]})
        else $error("word compare cost wrong");
    a_dword_imm: assert property (take && op_class == 2'h2 && (form == 5'h09 || form == 5'h0a) |=>
        instr_bytes == ($past(source_mode) ? 3'h4 : 3'h5) && exec_states == {3'h0, instr_bytes} + 6'h01)
        else $error("dword immediate compare cost wrong");
    a_ext_penalty: assert property (take && op_class == 2'h2 && form == 5'h0d && operand_loc == 2'h3
        && !source_mode |=> exec_states == 6'h05 + {2'h0, $past(wait_states)})
        else $error("external penalty wrong");
    a_io_port: assert property (take && (op_class == 2'h0 || op_class == 2'h2) && form == 5'h0b
        && operand_loc == 2'h1 && !source_mode |=> exec_states == 6'h04)
        else $error("port penalty wrong");
    a_carry_bank: assert property (take && op_class == 2'h1 && form == 5'h00 |=>
        instr_bytes == ($past(source_mode) ? 3'h2 : 3'h1) && exec_states == {3'h0, instr_bytes})
        else $error("carry bank form cost wrong");
    a_illegal_idle: assert property (take && op_class == 2'h3 ##1 !start |-> illegal && !busy ##1 !busy)
        else $error("refused request went busy");
    c_compare: cover property (done && cls == 2'h2);
    c_external: cover property (take && operand_loc == 2'h3 && form == 5'h0d);
    c_refused: cover property (illegal);
endmodule
bind arith_compare_timing arith_compare_timing_asserts chk (.clk_sys, .rst, .start, .op_class,
    .form, .source_mode, .operand_loc, .wait_states, .busy, .done, .illegal, .instr_bytes,
    .exec_states, .write_back);
`default_nettype wire

// ===== tb/arith_compare_timing_tb_top.sv
// self-checking bench for the add/subtract/compare timing unit
`timescale 1ns/10ps
`default_nettype none
module arith_compare_timing_tb_top;
    logic        clk_sys, rst, start, subtract, source_mode, carry_in, op_valid, wb;
    logic [1:0]  op_class, operand_loc;
    logic [4:0]  form;
    logic [3:0]  wait_states;
    logic [31:0] op_a, op_b, dest_operand, src_operand, result;
    logic        busy, done, illegal, write_back, carry_out, overflow, zero, negative;
    logic [2:0]  instr_bytes;
    logic [5:0]  exec_states;
    int          n_errors, checks_done;

    arith_compare_timing uut (.clk_sys, .rst, .start, .op_class, .subtract, .form,
        .source_mode, .operand_loc, .wait_states, .dest_operand, .src_operand, .carry_in,
        .busy, .done, .illegal, .instr_bytes, .exec_states, .result, .write_back,
        .carry_out, .overflow, .zero, .negative);
    operand_store mem (.clk_sys, .rst, .valid(op_valid), .a_in(op_a), .b_in(op_b),
        .dest_operand, .src_operand);

    always #2 clk_sys = ~clk_sys;

    task automatic fail(input string m);
        n_errors++;
        $display("mismatch at %0t: %s", $time, m);
    endtask

    // operands are presented one edge ahead because the store model registers them
    task automatic run(input logic [1:0] c, input logic sb, input logic [4:0] f,
            input logic sm, input logic [1:0] l, input logic [3:0] n, input int eb, es);
        int k;
        @(posedge clk_sys);
        {op_class, subtract, form, source_mode, operand_loc, wait_states} <= {c, sb, f, sm, l, n};
        op_valid <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        op_valid <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (done !== 1'b1 && k < 100);
        wb = write_back;
        checks_done += 4;
        if (instr_bytes !== eb[2:0]) fail("length");
        if (exec_states !== es[5:0]) fail("states");
        if (k != es + 1) fail("busy span");
        if (illegal !== 1'b0) fail("legal request refused");
    endtask

    task automatic pair(input logic [1:0] c, input logic [4:0] f, input int b1, s1, b2, s2);
        run(c, 1'b0, f, 1'b0, 2'h0, 4'h0, b1, s1);
        run(c, 1'b1, f, 1'b1, 2'h0, 4'h0, b2, s2);
    endtask

    task automatic t_add_sub;
        pair(2'h0, 5'h0c, 4, 4, 3, 3);
        pair(2'h0, 5'h0d, 5, 3, 4, 2);
        pair(2'h0, 5'h0e, 5, 4, 4, 3);
        pair(2'h0, 5'h0f, 4, 3, 3, 2);
        pair(2'h0, 5'h10, 4, 4, 3, 3);
        $display("t_add_sub finished");
    endtask

    task automatic t_carry;
        pair(2'h1, 5'h00, 1, 1, 2, 2);
        pair(2'h1, 5'h03, 2, 1, 2, 1);
        pair(2'h1, 5'h01, 2, 1, 2, 1);
        pair(2'h1, 5'h02, 1, 2, 2, 3);
        @(posedge clk_sys);
        op_a <= 32'h00000010;
        op_b <= 32'h00000001;
        carry_in <= 1'b1;
        run(2'h1, 1'b0, 5'h03, 1'b0, 2'h0, 4'h0, 2, 1);
        checks_done += 2;
        if (result !== 32'h00000012) fail("sum with carry");
        if (wb !== 1'b1) fail("sum not written");
        run(2'h1, 1'b1, 5'h03, 1'b0, 2'h0, 4'h0, 2, 1);
        checks_done++;
        if (result !== 32'h0000000e) fail("difference with borrow");
        @(posedge clk_sys);
        carry_in <= 1'b0;
        $display("t_carry finished");
    endtask

    task automatic t_compare;
        pair(2'h2, 5'h05, 3, 3, 2, 2);
        pair(2'h2, 5'h06, 3, 5, 2, 4);
        pair(2'h2, 5'h07, 4, 3, 3, 2);
        pair(2'h2, 5'h08, 5, 4, 4, 3);
        pair(2'h2, 5'h09, 5, 6, 4, 5);
        pair(2'h2, 5'h0a, 5, 6, 4, 5);
        pair(2'h2, 5'h0b, 4, 3, 3, 2);
        pair(2'h2, 5'h0c, 4, 4, 3, 3);
        pair(2'h2, 5'h0d, 5, 3, 4, 2);
        pair(2'h2, 5'h0e, 5, 4, 4, 3);
        pair(2'h2, 5'h0f, 4, 3, 3, 2);
        pair(2'h2, 5'h10, 4, 4, 3, 3);
        // same low half: only the upper fill decides equality
        @(posedge clk_sys);
        op_a <= 32'hffff1234;
        op_b <= 32'h00001234;
        run(2'h2, 1'b0, 5'h0a, 1'b0, 2'h0, 4'h0, 5, 6);
        checks_done += 2;
        if (zero !== 1'b1) fail("one-filled compare not equal");
        if (wb !== 1'b0) fail("compare wrote back");
        run(2'h2, 1'b0, 5'h09, 1'b0, 2'h0, 4'h0, 5, 6);
        checks_done++;
        if (zero !== 1'b0) fail("zero-filled compare equal");
        // word compare flags: a borrow case, then a signed overflow case
        @(posedge clk_sys);
        op_a <= 32'h00000001;
        op_b <= 32'h00000002;
        run(2'h2, 1'b0, 5'h05, 1'b0, 2'h0, 4'h0, 3, 3);
        checks_done += 3;
        if (carry_out !== 1'b1) fail("compare borrow missing");
        if (negative !== 1'b1) fail("compare sign missing");
        if (overflow !== 1'b0) fail("compare false overflow");
        @(posedge clk_sys);
        op_a <= 32'h00008000;
        op_b <= 32'h00000001;
        run(2'h2, 1'b0, 5'h05, 1'b1, 2'h0, 4'h0, 2, 2);
        checks_done += 3;
        if (overflow !== 1'b1) fail("compare overflow missing");
        if (carry_out !== 1'b0) fail("compare false borrow");
        if (negative !== 1'b0) fail("compare false sign");
        $display("t_compare finished");
    endtask

    task automatic t_penalty;
        run(2'h0, 1'b0, 5'h0b, 1'b0, 2'h1, 4'h0, 4, 4);
        run(2'h2, 1'b0, 5'h0b, 1'b1, 2'h2, 4'h0, 3, 4);
        run(2'h1, 1'b1, 5'h01, 1'b0, 2'h2, 4'h0, 2, 3);
        run(2'h2, 1'b0, 5'h0d, 1'b0, 2'h3, 4'hf, 5, 20);
        run(2'h0, 1'b1, 5'h0e, 1'b1, 2'h3, 4'h0, 4, 7);
        run(2'h2, 1'b0, 5'h10, 1'b1, 2'h3, 4'h3, 3, 8);
        run(2'h2, 1'b0, 5'h0c, 1'b0, 2'h1, 4'h0, 4, 4);
        $display("t_penalty finished");
    endtask

    task automatic t_refused;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            {op_class, form} <= (i == 0) ? {2'h3, 5'h05} : {2'h2, 5'h02};
            start <= 1'b1;
            @(posedge clk_sys);
            start <= 1'b0;
            repeat (2) @(negedge clk_sys);
            checks_done += 2;
            if (illegal !== 1'b1) fail("bad request not refused");
            if (busy !== 1'b0) fail("refused request went busy");
        end
        run(2'h2, 1'b0, 5'h05, 1'b0, 2'h0, 4'h0, 3, 3);
        $display("t_refused finished");
    endtask

    task automatic end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {start, subtract, source_mode, carry_in, op_valid} = 5'h00;
        {op_class, operand_loc, form, wait_states} = 13'h0000;
        op_a = 32'h00000000;
        op_b = 32'h00000000;
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        t_add_sub();
        t_carry();
        t_compare();
        t_penalty();
        t_refused();
        end_sim();
    end

    // the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
